// ===== design/supply_monitor_pkg.sv
// constants of the supply monitor: register map, field layout, reset values
package supply_monitor_pkg;

  // ------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam int unsigned STATUS_INDEX     = 32'h0000fe0f;
  localparam int unsigned CONFIG_INDEX     = 32'h0000fe10;
  localparam int unsigned EVENT_INDEX      = 32'h0000fe11;
  localparam int unsigned EVENT_CLR_INDEX  = 32'h0000fe12;
  localparam int unsigned EVENT_EN_INDEX   = 32'h0000fe13;
  localparam int unsigned BYTES_PER_REG    = 32'h00000004;
  localparam int unsigned ADDR_WIDTH_DEF   = 32'h00000012;

  // ------------------------------------------------------------------
  // status register fields
  // ------------------------------------------------------------------
  localparam int unsigned STAT_LOW_BIT     = 7;
  localparam int unsigned STAT_IE_BIT      = 6;
  localparam int unsigned STAT_IF_BIT      = 5;
  localparam int unsigned STAT_ACK_BIT     = 4;
  localparam logic [7:0]  STATUS_RESET     = 8'h00;

  // ------------------------------------------------------------------
  // configuration register fields
  // ------------------------------------------------------------------
  localparam int unsigned CFG_PWRD_BIT     = 0;
  localparam int unsigned CFG_RSTD_BIT     = 1;
  localparam int unsigned CFG_STOP_BIT     = 2;
  localparam int unsigned CFG_SEL_LSB      = 4;
  localparam int unsigned CFG_PIN_BIT      = 7;
  localparam logic        PWRD_RESET       = 1'b1;
  localparam logic        RSTD_RESET       = 1'b0;
  localparam logic        STOP_RESET       = 1'b0;
  localparam logic [1:0]  SEL_RESET        = 2'h0;

  // ------------------------------------------------------------------
  // event bits of the interrupt status, clear and enable registers
  // ------------------------------------------------------------------
  localparam int unsigned EVT_TOGGLE_BIT   = 0;
  localparam int unsigned EVT_RESET_BIT    = 1;
  localparam int unsigned EVT_COUNT        = 2;
  localparam logic [1:0]  EVT_RESET_VALUE  = 2'h0;

  // ------------------------------------------------------------------
  // bus answers
  // ------------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

// ===== design/low_voltage_supervisor.sv
// low-voltage supervisor: comparator sync, status, interrupt flag, reset request, AXI4-Lite registers
//
// Operation
// - out of reset monitoring is off
// - monitor only while power disable is zero
// - request reset on low supply if enabled
// - trip select picks 3.3V or 5V levels
// - status bit follows comparator with hysteresis
// - flag sets on every status bit change
// - cpu interrupt when flag and enable set
// - ack one clears flag, reads zero
// - flag read-only, cleared by reset
// - interrupt enable read-write, reset clears it
// - reset wins over irq, clears enable
// - hold reset until supply above rising level
// - drive external reset pin low while requesting
// - status register layout at fe0f
// - stays active in wait mode
// - active in stop only with stop enable or with wait mode also set
`timescale 1ns/1ns

module low_voltage_supervisor
  import supply_monitor_pkg::*;
#(
  parameter int unsigned ADDR_WIDTH = ADDR_WIDTH_DEF
)
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // axi4-lite slave
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  output      logic [1:0]            s_axi_bresp,
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  output      logic [31:0]           s_axi_rdata,
  output      logic [1:0]            s_axi_rresp,
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // analog comparator
  input  wire logic                  supply_below_async,
  output      logic                  comparator_enable,
  output      logic [1:0]            trip_level_select,
  // power modes of the processor
  input  wire logic                  wait_mode,
  input  wire logic                  stop_mode,
  // system side
  output      logic                  reset_request,
  output      logic                  cpu_irq,
  output      logic                  event_irq,
  // open-drain external reset pin
  input  wire logic                  reset_pin_in,
  output      logic                  reset_pin_out,
  output      logic                  reset_pin_oe_n
);

  // ------------------------------------------------------------------
  // addresses
  // ------------------------------------------------------------------
  localparam logic [ADDR_WIDTH-1:0] STATUS_ADDR    = ADDR_WIDTH'(STATUS_INDEX * BYTES_PER_REG);
  localparam logic [ADDR_WIDTH-1:0] CONFIG_ADDR    = ADDR_WIDTH'(CONFIG_INDEX * BYTES_PER_REG);
  localparam logic [ADDR_WIDTH-1:0] EVENT_ADDR     = ADDR_WIDTH'(EVENT_INDEX * BYTES_PER_REG);
  localparam logic [ADDR_WIDTH-1:0] EVENT_CLR_ADDR = ADDR_WIDTH'(EVENT_CLR_INDEX * BYTES_PER_REG);
  localparam logic [ADDR_WIDTH-1:0] EVENT_EN_ADDR  = ADDR_WIDTH'(EVENT_EN_INDEX * BYTES_PER_REG);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic                  comp_meta;
  logic                  comp_mid;
  logic                  comp_last;
  logic                  comp_stable;
  logic                  pin_meta;
  logic                  pin_mid;
  logic                  pin_last;
  logic                  pin_stable;

  logic                  power_disable;
  logic                  reset_disable;
  logic                  stop_enable;
  logic [1:0]            trip_select;

  logic                  supply_low_status;
  logic                  supply_irq_enable;
  logic                  supply_irq_flag;
  logic                  reset_hold;
  logic [EVT_COUNT-1:0]  event_status;
  logic [EVT_COUNT-1:0]  event_enable;

  logic [ADDR_WIDTH-1:0] aw_addr;
  logic                  aw_held;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  w_held;

  // ------------------------------------------------------------------
  // comparator and pin synchronisers
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      comp_meta <= 1'b0;
      comp_mid  <= 1'b0;
      comp_last <= 1'b0;
      pin_meta  <= 1'b1;
      pin_mid   <= 1'b1;
      pin_last  <= 1'b1;
    end
    else
    begin
      comp_meta <= supply_below_async;
      comp_mid  <= comp_meta;
      comp_last <= comp_mid;
      pin_meta  <= reset_pin_in;
      pin_mid   <= pin_meta;
      pin_last  <= pin_mid;
    end
  end

  // a change counts once the second and third stages agree
  wire comp_agree = comp_mid == comp_last;
  wire pin_agree  = pin_mid == pin_last;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      comp_stable <= 1'b0;
      pin_stable  <= 1'b1;
    end
    else
    begin
      if (comp_agree)
        comp_stable <= comp_last;
      if (pin_agree)
        pin_stable <= pin_last;
    end
  end

  // ------------------------------------------------------------------
  // monitoring state
  // ------------------------------------------------------------------
  // wait mode keeps the monitor running, even in stop mode; otherwise stop mode only with stop enable
  wire monitor_on    = !power_disable;
  wire stop_blocked  = stop_mode && !stop_enable;
  wire monitor_run   = monitor_on && (wait_mode || !stop_blocked);
  wire reset_allowed = monitor_run && !reset_disable;

  // the comparator hysteresis gives the keep-previous band between levels
  wire next_low      = monitor_run ? comp_stable : supply_low_status;
  wire status_toggle = next_low != supply_low_status;
  wire reset_trigger = reset_allowed && next_low && !reset_hold;
  wire reset_release = reset_hold && !comp_stable;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      supply_low_status <= STATUS_RESET[STAT_LOW_BIT];
      reset_hold        <= 1'b0;
    end
    else
    begin
      supply_low_status <= next_low;
      if (reset_trigger)
        reset_hold <= 1'b1;
      else if (reset_release)
        reset_hold <= 1'b0;
    end
  end

  assign comparator_enable = monitor_run;
  assign trip_level_select = trip_select;
  assign reset_request     = reset_hold;
  assign reset_pin_out     = 1'b0;
  assign reset_pin_oe_n    = !reset_hold;

  // ------------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------------
  wire write_go      = aw_held && w_held && !s_axi_bvalid;
  wire lane0         = w_strb[0];
  wire hit_status_w  = aw_addr == STATUS_ADDR;
  wire hit_config_w  = aw_addr == CONFIG_ADDR;
  wire hit_event_w   = aw_addr == EVENT_ADDR;
  wire hit_clr_w     = aw_addr == EVENT_CLR_ADDR;
  wire hit_en_w      = aw_addr == EVENT_EN_ADDR;
  wire write_mapped  = hit_status_w || hit_config_w || hit_event_w || hit_clr_w || hit_en_w;
  wire status_write  = write_go && hit_status_w && lane0;
  wire config_write  = write_go && hit_config_w && lane0;
  wire clear_write   = write_go && hit_clr_w && lane0;
  wire enable_write  = write_go && hit_en_w && lane0;
  wire ack_write     = status_write && w_data[STAT_ACK_BIT];

  // ------------------------------------------------------------------
  // configuration register
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      power_disable <= PWRD_RESET;
      reset_disable <= RSTD_RESET;
      stop_enable   <= STOP_RESET;
      trip_select   <= SEL_RESET;
    end
    else if (config_write)
    begin
      power_disable <= w_data[CFG_PWRD_BIT];
      reset_disable <= w_data[CFG_RSTD_BIT];
      stop_enable   <= w_data[CFG_STOP_BIT];
      trip_select   <= w_data[CFG_SEL_LSB+:2];
    end
  end

  // ------------------------------------------------------------------
  // interrupt flag and enable
  // ------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      supply_irq_flag   <= STATUS_RESET[STAT_IF_BIT];
      supply_irq_enable <= STATUS_RESET[STAT_IE_BIT];
    end
    else
    begin
      // a toggle in the acknowledge cycle still sets the flag
      if (status_toggle)
        supply_irq_flag <= 1'b1;
      else if (ack_write)
        supply_irq_flag <= 1'b0;
      if (reset_trigger)
        supply_irq_enable <= 1'b0;
      else if (status_write)
        supply_irq_enable <= w_data[STAT_IE_BIT];
    end
  end

  // no cpu interrupt while a reset is being requested
  assign cpu_irq = supply_irq_flag && supply_irq_enable && !reset_hold;

  // ------------------------------------------------------------------
  // event status, clear and enable
  // ------------------------------------------------------------------
  wire [EVT_COUNT-1:0] event_set;
  assign event_set[EVT_TOGGLE_BIT] = status_toggle;
  assign event_set[EVT_RESET_BIT]  = reset_trigger;

  genvar gi;
  generate
    for (gi = 0; gi < EVT_COUNT; gi++)
    begin : g_event
      always_ff @(posedge clk)
      begin
        if (!resetn)
          event_status[gi] <= EVT_RESET_VALUE[gi];
        else if (event_set[gi])
          event_status[gi] <= 1'b1;
        else if (clear_write && w_data[gi])
          event_status[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!resetn)
      event_enable <= EVT_RESET_VALUE;
    else if (enable_write)
      event_enable <= w_data[EVT_COUNT-1:0];
  end

  assign event_irq = |(event_status & event_enable);

  // ------------------------------------------------------------------
  // axi write channels
  // ------------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      aw_held      <= 1'b0;
      aw_addr      <= '0;
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (write_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= write_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------------
  wire hit_status_r = s_axi_araddr == STATUS_ADDR;
  wire hit_config_r = s_axi_araddr == CONFIG_ADDR;
  wire hit_event_r  = s_axi_araddr == EVENT_ADDR;
  wire hit_clr_r    = s_axi_araddr == EVENT_CLR_ADDR;
  wire hit_en_r     = s_axi_araddr == EVENT_EN_ADDR;
  wire read_mapped  = hit_status_r || hit_config_r || hit_event_r || hit_clr_r || hit_en_r;

  // acknowledge and low nibble read zero
  wire [7:0] status_value = {supply_low_status, supply_irq_enable, supply_irq_flag, 5'h00};

  wire [7:0] config_value = {pin_stable, 1'b0, trip_select, 1'b0, stop_enable, reset_disable, power_disable};

  wire [31:0] read_value = hit_status_r ? {24'h000000, status_value} :
                           hit_config_r ? {24'h000000, config_value} :
                           hit_event_r  ? {30'h00000000, event_status} :
                           hit_en_r     ? {30'h00000000, event_enable} :
                                          32'h00000000;

  // ------------------------------------------------------------------
  // axi read channels
  // ------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= read_value;
      s_axi_rresp  <= read_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// ===== verif/supply_monitor_sva.sv
// concurrent checks on the ports of the low-voltage supervisor
`timescale 1ns/1ns

module supply_monitor_sva
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        supply_below_async,
  input wire logic        comparator_enable,
  input wire logic        reset_request,
  input wire logic        cpu_irq,
  input wire logic        reset_pin_out,
  input wire logic        reset_pin_oe_n,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_quiet_after_reset: assert property ($rose(resetn) |-> !comparator_enable && !reset_request && !cpu_irq)
    else $error("monitor active right after reset");
  a_reset_needs_monitor: assert property ($rose(reset_request) |-> $past(comparator_enable))
    else $error("reset request raised while monitoring off");
  a_reset_beats_irq: assert property (reset_request |-> !cpu_irq)
    else $error("cpu interrupt during reset request");
  a_reset_holds_low: assert property (supply_below_async [*5] ##0 reset_request |=> reset_request)
    else $error("reset request dropped while supply low");
  a_reset_release: assert property (!supply_below_async [*6] |-> !reset_request)
    else $error("reset request held after supply recovered");
  a_pin_driven_low: assert property (reset_request |-> !reset_pin_oe_n && !reset_pin_out)
    else $error("reset pin not driven low");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
endmodule

bind low_voltage_supervisor supply_monitor_sva checker_i (.clk(clk), .resetn(resetn),
  .supply_below_async(supply_below_async), .comparator_enable(comparator_enable),
  .reset_request(reset_request), .cpu_irq(cpu_irq), .reset_pin_out(reset_pin_out),
  .reset_pin_oe_n(reset_pin_oe_n), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rdata(s_axi_rdata));

// ===== verif/supply_comparator_model.sv
// behavioural analog supply comparator with hysteresis
`timescale 1ns/1ns

module supply_comparator_model
#(
  parameter int FALL_LOW_MV  = 3000,
  parameter int RISE_LOW_MV  = 3100,
  parameter int FALL_HIGH_MV = 4300,
  parameter int RISE_HIGH_MV = 4400
)
(
  input  wire logic [15:0] supply_mv,
  input  wire logic [1:0]  trip_level_select,
  output      logic        supply_below_async
);
  logic [15:0] fall_mv;
  logic [15:0] rise_mv;

  // select value 1 is the 3.3V level pair in this model
  assign fall_mv = trip_level_select[0] ? 16'(FALL_LOW_MV) : 16'(FALL_HIGH_MV);
  assign rise_mv = trip_level_select[0] ? 16'(RISE_LOW_MV) : 16'(RISE_HIGH_MV);

  initial supply_below_async = 1'b0;

  // between the two levels the output keeps its last value
  always @(supply_mv or fall_mv or rise_mv)
  begin
    if (supply_mv < fall_mv)
      supply_below_async = 1'b1;
    else if (supply_mv > rise_mv)
      supply_below_async = 1'b0;
  end
endmodule

// ===== verif/low_voltage_supervisor_test.sv
// self-checking bench of the low-voltage supervisor
`timescale 1ns/1ns

module low_voltage_supervisor_test
  import supply_monitor_pkg::*;
;
  logic        clk;
  logic        resetn;
  logic [17:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [17:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [15:0] supply_mv;
  logic        below;
  logic        comparator_enable;
  logic [1:0]  trip_level_select;
  logic        wait_mode;
  logic        stop_mode;
  logic        reset_request;
  logic        cpu_irq;
  logic        event_irq;
  logic        reset_pin_out;
  logic        reset_pin_oe_n;
  logic        pin_level;
  int          failures;
  int          num_checks;
  int          cycles;

  // open-drain reset pin with pull-up
  assign pin_level = reset_pin_oe_n ? 1'b1 : reset_pin_out;

  low_voltage_supervisor DUT (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .supply_below_async(below), .comparator_enable(comparator_enable),
    .trip_level_select(trip_level_select), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .reset_request(reset_request), .cpu_irq(cpu_irq), .event_irq(event_irq), .reset_pin_in(pin_level),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n));

  supply_comparator_model analog (.supply_mv(supply_mv), .trip_level_select(trip_level_select),
    .supply_below_async(below));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict;
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      give_verdict;
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic bus_write(input int unsigned idx, input logic [7:0] val, output logic [1:0] resp);
    logic aw_busy;
    logic w_busy;
    logic done;
    aw_busy = 1'b1;
    w_busy = 1'b1;
    done = 1'b0;
    awaddr <= 18'(idx * BYTES_PER_REG);
    wdata <= {24'h000000, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (aw_busy && awready)
      begin
        aw_busy = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_busy && wready)
      begin
        w_busy = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid)
      begin
        done = 1'b1;
        resp = bresp;
        bready <= 1'b0;
      end
    end
    @(posedge clk);
  endtask

  task automatic bus_read(input int unsigned idx, output logic [31:0] data, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    araddr <= 18'(idx * BYTES_PER_REG);
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        done = 1'b1;
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
      end
    end
    @(posedge clk);
  endtask

  task automatic wr(input int unsigned idx, input logic [7:0] val);
    logic [1:0] resp;
    bus_write(idx, val, resp);
    check_word({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd(input int unsigned idx, input logic [7:0] exp);
    logic [31:0] data;
    logic [1:0]  resp;
    bus_read(idx, data, resp);
    check_word({30'h0, resp}, {30'h0, RESP_OKAY});
    check_word(data, {24'h000000, exp});
  endtask

  task automatic supply(input logic [15:0] mv);
    supply_mv <= mv;
    repeat (6) @(posedge clk);
  endtask

  initial
  begin
    logic [31:0] data;
    logic [1:0]  resp;
    failures = 0;
    num_checks = 0;
    cycles = 0;
    resetn = 1'b0;
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    {wait_mode, stop_mode} = 2'b00;
    supply_mv = 16'd5000;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    rd(STATUS_INDEX, 8'h00);
    rd(CONFIG_INDEX, 8'h81);
    rd(EVENT_INDEX, 8'h00);
    check_bit(comparator_enable, 1'b0);
    bus_write(32'h0000fe14, 8'h01, resp);
    check_word({30'h0, resp}, {30'h0, RESP_SLVERR});
    bus_read(32'h0000fe14, data, resp);
    check_word({30'h0, resp}, {30'h0, RESP_SLVERR});
    supply(16'd1000);
    rd(STATUS_INDEX, 8'h00);
    check_bit(reset_request, 1'b0);
    supply(16'd5000);
    wr(CONFIG_INDEX, 8'h13);
    wr(CONFIG_INDEX, 8'h12);
    check_word({30'h0, trip_level_select}, 32'h00000001);
    check_bit(comparator_enable, 1'b1);
    wr(STATUS_INDEX, 8'h40);
    rd(STATUS_INDEX, 8'h40);
    wr(EVENT_EN_INDEX, 8'h01);
    supply(16'd3050);
    rd(STATUS_INDEX, 8'h40);
    supply(16'd2000);
    rd(STATUS_INDEX, 8'he0);
    check_bit(cpu_irq, 1'b1);
    check_bit(reset_request, 1'b0);
    supply(16'd3050);
    rd(STATUS_INDEX, 8'he0);
    wr(STATUS_INDEX, 8'h50);
    rd(STATUS_INDEX, 8'hc0);
    check_bit(cpu_irq, 1'b0);
    supply(16'd5000);
    rd(STATUS_INDEX, 8'h60);
    wr(STATUS_INDEX, 8'h40);
    rd(STATUS_INDEX, 8'h60);
    wr(STATUS_INDEX, 8'hdf);
    rd(STATUS_INDEX, 8'h40);
    rd(EVENT_INDEX, 8'h01);
    check_bit(event_irq, 1'b1);
    wr(EVENT_EN_INDEX, 8'h00);
    check_bit(event_irq, 1'b0);
    wr(EVENT_EN_INDEX, 8'h01);
    wr(EVENT_CLR_INDEX, 8'h03);
    check_bit(event_irq, 1'b0);
    rd(EVENT_INDEX, 8'h00);
    rd(EVENT_CLR_INDEX, 8'h00);
    wr(CONFIG_INDEX, 8'h10);
    supply(16'd2000);
    check_bit(reset_request, 1'b1);
    check_bit(reset_pin_oe_n, 1'b0);
    check_bit(cpu_irq, 1'b0);
    rd(STATUS_INDEX, 8'ha0);
    rd(CONFIG_INDEX, 8'h10);
    supply(16'd3050);
    check_bit(reset_request, 1'b1);
    supply(16'd5000);
    check_bit(reset_request, 1'b0);
    check_bit(reset_pin_oe_n, 1'b1);
    rd(STATUS_INDEX, 8'h20);
    wr(STATUS_INDEX, 8'h10);
    stop_mode <= 1'b1;
    supply(16'd5000);
    check_bit(comparator_enable, 1'b0);
    wr(CONFIG_INDEX, 8'h14);
    check_bit(comparator_enable, 1'b1);
    supply(16'd2000);
    check_bit(reset_request, 1'b1);
    supply(16'd5000);
    stop_mode <= 1'b0;
    wait_mode <= 1'b1;
    wr(CONFIG_INDEX, 8'h10);
    supply(16'd2000);
    check_bit(reset_request, 1'b1);
    supply(16'd5000);
    give_verdict;
  end
endmodule
